// *** card_mode_pkg.sv ***
// Constants shared by the card slot mode switch
package card_mode_pkg;
   // ==========================================
   // Bus widths and answers
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // ==========================================
   // Register indices, byte address is four times the index
   localparam logic [7:0] IDX_POWER = 8'h29;
   localparam logic [7:0] IDX_IFACE = 8'h55;
   localparam logic [7:0] IDX_CAPS_LO = 8'h40;
   localparam logic [7:0] IDX_CAPS_HI = 8'h41;
   localparam logic [7:0] IDX_STATUS = 8'h60;
   // ==========================================
   // Field positions
   localparam int BIT_SUPPLY_ON = 4;
   localparam int BIT_IFACE_EN = 0;
   localparam int BIT_PCIE_CAP = 20;
   localparam int BIT_SUPPLY2_CAP = 28;
   localparam int BIT_ST_MODE = 0;
   localparam int BIT_ST_DETECT = 1;
   localparam int BIT_ST_CLKREQ = 2;
   localparam int BIT_ST_PRSNT = 3;
   // ==========================================
   // Reset and fixed values
   localparam logic RST_SUPPLY_ON = 1'b0;
   localparam logic RST_IFACE_EN = 1'b0;
   localparam logic PCIE_CAPABLE = 1'b1;
   localparam logic [3:0] SD_IDLE = 4'hf;
endpackage

// *** mode_ctrl_if.sv ***
// Mode control between register logic and the pin switch
`timescale 1ns/1ps
interface mode_ctrl_if;
   logic pcie_mode;
   logic clkreq_level;
   modport ctrl (output pcie_mode, input clkreq_level);
   modport sw (input pcie_mode, output clkreq_level);
endinterface

// *** card_pin_mux.sv ***
// Pin switch between the SD data lines and the PCIe signals
`timescale 1ns/1ps
module card_pin_mux (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Mode control
   mode_ctrl_if.sw ctl,
   // SD controller side
   input wire logic [3:0] sd_dat_out,
   input wire logic [3:0] sd_dat_oe,
   output logic [3:0] sd_dat_in,
   // PCIe unit side
   input wire logic pcie_perst_n,
   input wire logic pcie_clkreq_pull,
   output logic pcie_clkreq_n_in,
   input wire logic pcie_refclk,
   input wire logic pcie_tx,
   output logic pcie_rx,
   // Card socket side
   output logic [3:0] card_dat_out,
   output logic [3:0] card_dat_oe,
   input wire logic [3:0] card_dat_in
);
   import card_mode_pkg::*;

   // ==========================================
   // Routing toward the card
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         card_dat_out <= 4'h0;
         card_dat_oe <= 4'h0;
      end else if (ctl.pcie_mode) begin
         card_dat_out <= {pcie_perst_n, 1'b0, pcie_tx, pcie_refclk};
         card_dat_oe <= {1'b1, pcie_clkreq_pull, 2'h3};
      end else begin
         card_dat_out <= sd_dat_out;
         card_dat_oe <= sd_dat_oe;
      end
   end

   // ==========================================
   // Routing from the card
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         sd_dat_in <= SD_IDLE;
         pcie_clkreq_n_in <= 1'b1;
         pcie_rx <= 1'b0;
      end else if (ctl.pcie_mode) begin
         sd_dat_in <= SD_IDLE;
         pcie_clkreq_n_in <= card_dat_in[2];
         pcie_rx <= card_dat_in[1];
      end else begin
         sd_dat_in <= card_dat_in;
         pcie_clkreq_n_in <= 1'b1;
         pcie_rx <= 1'b0;
      end
   end

   assign ctl.clkreq_level = pcie_clkreq_n_in;

   // ==========================================
   // Checks
   logic run_ok;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         run_ok <= 1'b0;
      end else begin
         run_ok <= 1'b1;
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   perst_route_a: assert property ($past(ctl.pcie_mode) |->
      card_dat_out[3] == $past(pcie_perst_n) && card_dat_oe[3])
      else $error("Reset sideband not driven to line 3");
   clkreq_drain_a: assert property ($past(ctl.pcie_mode) |->
      !card_dat_out[2] && card_dat_oe[2] == $past(pcie_clkreq_pull))
      else $error("Clock request line not open drain");
   lane_route_a: assert property ($past(ctl.pcie_mode) |->
      card_dat_out[1:0] == {$past(pcie_tx), $past(pcie_refclk)}
      && pcie_rx == $past(card_dat_in[1]))
      else $error("Lane or refclk not on lines 0 and 1");
   one_function_a: assert property ($past(ctl.pcie_mode) |->
      sd_dat_in == SD_IDLE)
      else $error("SD lines see card while in PCIe mode");
   sd_route_a: assert property (run_ok && !$past(ctl.pcie_mode) |->
      card_dat_oe == $past(sd_dat_oe) && pcie_clkreq_n_in)
      else $error("SD routing broken in SD mode");
endmodule

// *** card_bus_mode_switch.sv ***
// Mode switch for a card slot shared by SD and PCIe
//
// Our own choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
module card_bus_mode_switch (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // AXI4-Lite write address and data
   input wire logic [card_mode_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [card_mode_pkg::DATA_W-1:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read
   input wire logic [card_mode_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [card_mode_pkg::DATA_W-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // SD controller side
   input wire logic [3:0] sd_dat_out,
   input wire logic [3:0] sd_dat_oe,
   output logic [3:0] sd_dat_in,
   output logic sd_card_detect_n,
   // PCIe unit side
   input wire logic pcie_perst_n,
   input wire logic pcie_clkreq_pull,
   output logic pcie_clkreq_n_in,
   input wire logic pcie_refclk,
   input wire logic pcie_tx,
   output logic pcie_rx,
   output logic pcie_present_n,
   // Card socket and power
   output logic [3:0] card_dat_out,
   output logic [3:0] card_dat_oe,
   input wire logic [3:0] card_dat_in,
   input wire logic socket_detect_n,
   output logic second_supply_en
);
   import card_mode_pkg::*;

   logic second_supply_on;
   logic pcie_iface_enable;
   logic [ADDR_W-1:0] wr_addr;
   logic [DATA_W-1:0] wr_data;
   logic [3:0] wr_strb;
   logic aw_full;
   logic w_full;
   logic [DATA_W-1:0] next_rdata;
   logic rd_hit;
   mode_ctrl_if mode_bus ();

   function automatic logic reg_hit(input logic [ADDR_W-1:0] addr,
                                    input logic [7:0] idx);
      return addr[ADDR_W-1:2] == {2'h0, idx};
   endfunction

   // ==========================================
   // Write channel
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_awready <= 1'b1;
         aw_full <= 1'b0;
         wr_addr <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         s_axi_awready <= 1'b0;
         aw_full <= 1'b1;
         wr_addr <= s_axi_awaddr;
      end else if (s_axi_bvalid && s_axi_bready) begin
         s_axi_awready <= 1'b1;
         aw_full <= 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_wready <= 1'b1;
         w_full <= 1'b0;
         wr_data <= '0;
         wr_strb <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         s_axi_wready <= 1'b0;
         w_full <= 1'b1;
         wr_data <= s_axi_wdata;
         wr_strb <= s_axi_wstrb;
      end else if (s_axi_bvalid && s_axi_bready) begin
         s_axi_wready <= 1'b1;
         w_full <= 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else if (aw_full && w_full && !s_axi_bvalid) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= (reg_hit(wr_addr, IDX_POWER) ||
            reg_hit(wr_addr, IDX_IFACE) || reg_hit(wr_addr, IDX_CAPS_LO) ||
            reg_hit(wr_addr, IDX_CAPS_HI) || reg_hit(wr_addr, IDX_STATUS))
            ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // ==========================================
   // Control bits
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         second_supply_on <= RST_SUPPLY_ON;
         pcie_iface_enable <= RST_IFACE_EN;
      end else if (aw_full && w_full && !s_axi_bvalid) begin
         if (reg_hit(wr_addr, IDX_POWER) && wr_strb[0])
            second_supply_on <= wr_data[BIT_SUPPLY_ON];
         if (reg_hit(wr_addr, IDX_IFACE) && wr_strb[0])
            pcie_iface_enable <= wr_data[BIT_IFACE_EN];
      end
   end

   // ==========================================
   // Supply, mode and presence outputs
   assign mode_bus.pcie_mode = second_supply_on;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         second_supply_en <= 1'b0;
         pcie_present_n <= 1'b1;
         sd_card_detect_n <= 1'b1;
      end else begin
         second_supply_en <= second_supply_on;
         pcie_present_n <= !pcie_iface_enable;
         sd_card_detect_n <= socket_detect_n;
      end
   end

   // ==========================================
   // Read channel
   always_comb begin
      next_rdata = '0;
      rd_hit = 1'b1;
      if (reg_hit(s_axi_araddr, IDX_POWER))
         next_rdata[BIT_SUPPLY_ON] = second_supply_on;
      else if (reg_hit(s_axi_araddr, IDX_IFACE))
         next_rdata[BIT_IFACE_EN] = pcie_iface_enable;
      else if (reg_hit(s_axi_araddr, IDX_CAPS_LO))
         next_rdata[BIT_PCIE_CAP] = PCIE_CAPABLE;
      else if (reg_hit(s_axi_araddr, IDX_CAPS_HI))
         next_rdata[BIT_SUPPLY2_CAP] = PCIE_CAPABLE;
      else if (reg_hit(s_axi_araddr, IDX_STATUS)) begin
         next_rdata[BIT_ST_MODE] = second_supply_on;
         next_rdata[BIT_ST_DETECT] = !sd_card_detect_n;
         next_rdata[BIT_ST_CLKREQ] = mode_bus.clkreq_level;
         next_rdata[BIT_ST_PRSNT] = pcie_present_n;
      end else
         rd_hit = 1'b0;
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= next_rdata;
         s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
      end
   end

   // ==========================================
   // Pin switch
   card_pin_mux pin_mux (
      .mclk(mclk),
      .rst_n(rst_n),
      .ctl(mode_bus.sw),
      .sd_dat_out(sd_dat_out),
      .sd_dat_oe(sd_dat_oe),
      .sd_dat_in(sd_dat_in),
      .pcie_perst_n(pcie_perst_n),
      .pcie_clkreq_pull(pcie_clkreq_pull),
      .pcie_clkreq_n_in(pcie_clkreq_n_in),
      .pcie_refclk(pcie_refclk),
      .pcie_tx(pcie_tx),
      .pcie_rx(pcie_rx),
      .card_dat_out(card_dat_out),
      .card_dat_oe(card_dat_oe),
      .card_dat_in(card_dat_in)
   );

   // ==========================================
   // Checks
   logic run_ok;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         run_ok <= 1'b0;
      end else begin
         run_ok <= 1'b1;
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   sequence power_write_s;
      aw_full && w_full && !s_axi_bvalid && reg_hit(wr_addr, IDX_POWER)
         && wr_strb[0];
   endsequence

   supply_write_a: assert property (power_write_s |-> ##2
      second_supply_en == $past(wr_data[BIT_SUPPLY_ON], 2))
      else $error("Supply write not reflected two cycles later");
   supply_mode_a: assert property ($past(second_supply_en) ==
      $past(mode_bus.pcie_mode, 2))
      else $error("Supply enable and mode disagree");
   present_level_a: assert property (run_ok |-> pcie_present_n ==
      !$past(pcie_iface_enable))
      else $error("Presence line does not follow enable bit");
   detect_pass_a: assert property (run_ok |-> sd_card_detect_n ==
      $past(socket_detect_n))
      else $error("Card detect not passed to SD controller");
   caps_read_a: assert property (s_axi_arvalid && s_axi_arready &&
      reg_hit(s_axi_araddr, IDX_CAPS_HI) |=> s_axi_rvalid &&
      s_axi_rdata[BIT_SUPPLY2_CAP] == PCIE_CAPABLE)
      else $error("Second supply capability bit wrong");
   reset_state_a: assert property ($rose(rst_n) |-> pcie_present_n &&
      !second_supply_en && card_dat_oe == 4'h0)
      else $error("Outputs not at reset state");
endmodule

// *** card_model.sv ***
// Card side of the shared data lines, with host pull-up on line 2
`timescale 1ns/1ps
module card_model (
   // Clock
   input wire logic mclk,
   // Block pin drive
   input wire logic [3:0] card_dat_out,
   input wire logic [3:0] card_dat_oe,
   // Card drive, commanded by the bench
   input wire logic [3:0] card_drive,
   input wire logic [3:0] card_val,
   // Resolved line levels
   output logic [3:0] card_dat_in
);
   logic flt = 1'b0;
   // ==========================================
   // Released lines other than line 2 show a changing pattern
   always_ff @(posedge mclk) begin
      flt <= ~flt;
   end
   // ==========================================
   // Line resolution
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         if (card_dat_oe[i]) begin
            card_dat_in[i] = card_dat_out[i];
         end else if (card_drive[i]) begin
            card_dat_in[i] = card_val[i];
         end else if (i == 2) begin
            card_dat_in[i] = 1'b1;
         end else begin
            card_dat_in[i] = flt ^ i[0];
         end
      end
   end
endmodule

// *** tb_card_bus_mode_switch.sv ***
// Self-checking bench for the card slot mode switch
`timescale 1ns/1ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin errors++; \
   $display("BAD %0t got %h want %h", $time, a, e); end end
module tb_card_bus_mode_switch;
   import card_mode_pkg::*;
   logic mclk, rst_n, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, sd_card_detect_n, perst_n;
   logic hpull, clkreq_n_in, refclk, tx, rx, present_n, sock_n, supply_en;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [1:0] bresp, rresp, ew;
   logic [33:0] er;
   logic [3:0] wstrb, sd_out, sd_oe, sd_in, c_out, c_oe, c_in, c_drv, c_val;
   logic [1:0] wq[$];
   logic [33:0] rq[$];
   int errors = 0;
   int cmp_count = 0;
   int cycles = 0;
   card_bus_mode_switch uut (.mclk(mclk), .rst_n(rst_n),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .sd_dat_out(sd_out),
      .sd_dat_oe(sd_oe), .sd_dat_in(sd_in), .sd_card_detect_n(sd_card_detect_n),
      .pcie_perst_n(perst_n), .pcie_clkreq_pull(hpull),
      .pcie_clkreq_n_in(clkreq_n_in), .pcie_refclk(refclk), .pcie_tx(tx),
      .pcie_rx(rx), .pcie_present_n(present_n), .card_dat_out(c_out),
      .card_dat_oe(c_oe), .card_dat_in(c_in), .socket_detect_n(sock_n),
      .second_supply_en(supply_en));
   card_model card (.mclk(mclk), .card_dat_out(c_out), .card_dat_oe(c_oe),
      .card_drive(c_drv), .card_val(c_val), .card_dat_in(c_in));
   // ==========================================
   // Clock, watchdog and response scoreboard
   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cycles++;
      if (cycles > 4000) begin
         errors++;
         summarize();
      end
   end
   always @(posedge mclk) begin
      if (bvalid && bready) begin
         ew = wq.pop_front();
         `CHK(bresp, ew)
      end
      if (rvalid && rready) begin
         er = rq.pop_front();
         `CHK({rresp, rdata}, er)
      end
   end
   // ==========================================
   // Tasks
   task automatic summarize();
      $display("errors=%0d compares=%0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic settle();
      repeat (2) @(posedge mclk);
      #1;
   endtask
   task automatic wr(input logic [7:0] idx, input logic [31:0] d,
                     input logic [3:0] s, input logic [1:0] r);
      @(posedge mclk);
      wq.push_back(r);
      awaddr <= {2'h0, idx, 2'h0};
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge mclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (!bvalid);
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] idx, input logic [31:0] d,
                     input logic [1:0] r);
      @(posedge mclk);
      rq.push_back({r, d});
      araddr <= {2'h0, idx, 2'h0};
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge mclk);
         if (arvalid && arready) arvalid <= 1'b0;
      end while (!rvalid);
      rready <= 1'b0;
   endtask
   task automatic do_reset();
      @(posedge mclk);
      rst_n <= 1'b0;
      repeat (4) @(posedge mclk);
      #1 `CHK({supply_en, present_n, c_oe}, 6'h10)
      @(posedge mclk);
      rst_n <= 1'b1;
   endtask
   task automatic pin_round(input logic pm);
      logic [31:0] v;
      logic [3:0] ex, m;
      for (int i = 0; i < 8; i++) begin
         @(posedge mclk);
         v = $urandom;
         sd_out <= v[3:0];
         sd_oe <= v[7:4];
         {perst_n, tx, refclk, hpull} <= v[19:16];
         c_drv <= pm ? {1'b0, v[20], 2'b0} : (v[11:8] & ~v[7:4]);
         c_val <= pm ? 4'h0 : v[15:12];
         settle();
         if (pm) begin
            `CHK(c_out, {v[19], 1'b0, v[18], v[17]})
            `CHK(c_oe, {1'b1, v[16], 2'b11})
            `CHK(sd_in, SD_IDLE)
            `CHK({clkreq_n_in, rx}, {~(v[16] | v[20]), v[18]})
         end else begin
            ex = (v[7:4] & v[3:0]) | (~v[7:4] & v[11:8] & v[15:12]);
            ex = ex | (~v[7:4] & ~v[11:8] & 4'h4);
            m = v[7:4] | v[11:8] | 4'h4;
            `CHK(c_out, v[3:0])
            `CHK(c_oe, v[7:4])
            `CHK(sd_in & m, ex & m)
            `CHK({supply_en, rx, clkreq_n_in}, 3'b001)
         end
      end
   endtask
   task automatic detect_round(input logic pn);
      for (int i = 0; i < 4; i++) begin
         @(posedge mclk);
         sock_n <= i[0];
         settle();
         `CHK(sd_card_detect_n, i[0])
         `CHK(present_n, pn)
      end
   endtask
   // ==========================================
   // Main sequence
   initial begin
      {rst_n, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
      {awaddr, araddr, wdata, wstrb} = 60'h0;
      {sd_out, sd_oe, c_drv, c_val} = 16'h0;
      {perst_n, hpull, refclk, tx, sock_n} = 5'h11;
      void'($urandom(32'h0f7584aa));
      do_reset();
      rd(IDX_POWER, 32'h0, RESP_OKAY);
      rd(IDX_IFACE, 32'h0, RESP_OKAY);
      rd(IDX_CAPS_LO, 32'(PCIE_CAPABLE) << BIT_PCIE_CAP, RESP_OKAY);
      rd(IDX_CAPS_HI, 32'h1 << BIT_SUPPLY2_CAP, RESP_OKAY);
      rd(8'hff, 32'h0, RESP_SLVERR);
      rd(IDX_STATUS, 32'hc, RESP_OKAY);
      pin_round(1'b0);
      detect_round(1'b1);
      wr(IDX_POWER, 32'h10, 4'h0, RESP_OKAY);
      settle();
      `CHK(supply_en, 1'b0)
      wr(IDX_POWER, 32'h1 << BIT_SUPPLY_ON, 4'h1, RESP_OKAY);
      settle();
      `CHK(supply_en, 1'b1)
      wr(IDX_CAPS_LO, 32'h0, 4'hf, RESP_OKAY);
      rd(IDX_CAPS_LO, 32'(PCIE_CAPABLE) << BIT_PCIE_CAP, RESP_OKAY);
      rd(IDX_POWER, 32'h10, RESP_OKAY);
      pin_round(1'b1);
      wr(IDX_IFACE, 32'h1, 4'h1, RESP_OKAY);
      detect_round(1'b0);
      wr(8'hff, 32'h0, 4'hf, RESP_SLVERR);
      wr(IDX_IFACE, 32'h0, 4'h1, RESP_OKAY);
      detect_round(1'b1);
      wr(IDX_POWER, 32'h0, 4'h1, RESP_OKAY);
      pin_round(1'b0);
      wr(IDX_POWER, 32'h10, 4'h1, RESP_OKAY);
      wr(IDX_IFACE, 32'h1, 4'h1, RESP_OKAY);
      settle();
      do_reset();
      rd(IDX_POWER, 32'h0, RESP_OKAY);
      settle();
      summarize();
   end
endmodule
